// File: logic/mms_top.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - database holds up to ten master symbols, each selected by index
// - sequential type or continuous one-output mode forces one symbol per read
// - comparison type 0 off, 1 plain, 2 wildcard, 3 sequential; off after reset
// - sequential compares numeric characters only and steps the master on match
// - count direction 0 counts up, 1 counts down; up after reset
// - start position 0 to 3000, reset 0; zero turns partial compare off
// - plain and sequential compare from start position, counted from one
// - length 1 to 3000, reset 1, sets compared characters from start
// - wildcard code programmable, asterisk after reset, matches any one char
// - trailing wildcards allow shorter symbols; other wildcards need equal length
// - step on no-read enabled after reset; disabled leaves master unchanged
// - step-on-mismatch only acts in sequential mode
// - step-on-mismatch enabled steps master on every mismatch; off after reset
// - with it off, first mismatch after a match steps, later ones do not
// - stepping sets master to decoded value on match, else to master, plus or minus the step
// - masters enter by indexed write, load-next command, or enabled pin pulse
// - step size programmable 1 to 32768, reset 1
// - count rolls over within the master digit count like a counter
module mms_top #(
   parameter int NMST = mms_pkg::MAX_MASTERS,
   parameter int NCH  = mms_pkg::SYM_CHARS
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             sym_valid,
   input  wire logic             sym_noread,
   input  wire logic [NCH*8-1:0] sym_data,
   input  wire logic [7:0]       sym_len,
   output logic                  sym_ready,
   input  wire logic             new_master_pin,
   output logic                  match_o,
   output logic                  mismatch_o,
   output logic      [3:0]       eff_symbols
);
   mms_pkg::mms_state_type st_ff;
   mms_pkg::mms_cmp_type   type_ff;
   logic                   dir_ff;
   logic                   snr_ff;
   logic                   smm_ff;
   logic                   cont_ff;
   logic                   pin_en_ff;
   logic [7:0]             wc_ff;
   logic [3:0]             nsym_ff;
   logic [3:0]             cnt_ff;
   logic [3:0]             sel_ff;
   logic [3:0]             load_idx_ff;
   logic [3:0]             scan_ff;
   logic [11:0]            start_ff;
   logic [11:0]            len_ff;
   logic [15:0]            step_ff;
   logic [NCH*8-1:0]       mst_ff [NMST];
   logic [7:0]             mlen_ff [NMST];
   logic [NCH*8-1:0]       sym_ff;
   logic [7:0]             slen_ff;
   logic                   noread_ff;
   logic                   hit_ff;
   logic                   last_hit_ff;
   logic                   last_mm_ff;
   logic                   step_go;
   logic                   pin_s1_ff;
   logic                   pin_s2_ff;
   logic                   pin_s3_ff;
   logic                   pin_pulse;
   logic                   bus_req;
   logic                   bus_wr;
   logic                   data_hit;
   logic [5:0]             dk;
   logic [31:0]            rd_mux;
   logic [31:0]            wmerge;

   mms_step_if #(.NCH(NCH)) sif();

   mms_digit_step #(.NCH(NCH)) u_step (
      .sif (sif.calc)
   );

   // byte-lane merge of a write into the current value
   function automatic logic [31:0] f_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // binary step size to five decimal digits
   function automatic logic [19:0] f_bcd(input logic [15:0] b);
      logic [35:0] w;
      w = {20'h00000, b};
      for (int i = 0; i < 16; i++) begin
         for (int d = 0; d < 5; d++) begin
            if (w[16+d*4 +: 4] > 4'h4) begin
               w[16+d*4 +: 4] = w[16+d*4 +: 4] + 4'h3;
            end
         end
         w = w << 1;
      end
      return w[35:16];
   endfunction

   // compare one symbol against one master
   function automatic logic f_match(input logic [NCH*8-1:0] s,
                                    input logic [7:0]       sl,
                                    input logic [NCH*8-1:0] m,
                                    input logic [7:0]       ml,
                                    input logic [1:0]       ty,
                                    input logic [7:0]       wc,
                                    input logic [11:0]      st,
                                    input logic [11:0]      ln);
      logic ok;
      int   tl;
      int   lo;
      int   hi;
      ok = 1'b1;
      tl = int'(ml);
      lo = 0;
      hi = int'(ml);
      if (ty == mms_pkg::CMP_WILD) begin
         for (int i = NCH - 1; i >= 0; i--) begin
            if (i == tl - 1 && m[i*8 +: 8] == wc) begin
               tl = i;
            end
         end
         if (int'(sl) < tl || sl > ml) begin
            ok = 1'b0;
         end
         for (int i = 0; i < NCH; i++) begin
            if (i < int'(sl) && m[i*8 +: 8] != wc && m[i*8 +: 8] != s[i*8 +: 8]) begin
               ok = 1'b0;
            end
         end
      end else begin
         if (st != 12'h000) begin
            lo = int'(st) - 1;
            hi = lo + int'(ln);
            if (int'(sl) < hi || int'(ml) < hi) begin
               ok = 1'b0;
            end
         end else if (sl != ml) begin
            ok = 1'b0;
         end
         for (int i = 0; i < NCH; i++) begin
            if (i >= lo && i < hi) begin
               if (s[i*8 +: 8] != m[i*8 +: 8]) begin
                  ok = 1'b0;
               end
               if (ty == mms_pkg::CMP_SEQ && (s[i*8 +: 8] < 8'h30 || s[i*8 +: 8] > 8'h39)) begin
                  ok = 1'b0;
               end
            end
         end
      end
      return ok;
   endfunction

   // bus decode
   assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr   = bus_req & wb_we_i;
   assign dk       = wb_adr_i[7:2] - mms_pkg::DWORD_BASE;
   assign data_hit = (wb_adr_i[7:6] != 2'h0) && (int'(dk) < NCH / 4);
   assign wmerge   = f_merge(rd_mux, wb_dat_i, wb_sel_i);

   // register read view
   always_comb begin
      rd_mux = 32'h00000000;
      case (wb_adr_i)
         mms_pkg::A_CFG: begin
            rd_mux[mms_pkg::F_TYPE +: 2] = type_ff;
            rd_mux[mms_pkg::F_DIR]       = dir_ff;
            rd_mux[mms_pkg::F_SNR]       = snr_ff;
            rd_mux[mms_pkg::F_SMM]       = smm_ff;
            rd_mux[mms_pkg::F_CONT]      = cont_ff;
            rd_mux[mms_pkg::F_WC +: 8]   = wc_ff;
            rd_mux[mms_pkg::F_NSYM +: 4] = nsym_ff;
         end
         mms_pkg::A_WIN: begin
            rd_mux[11:0]                  = start_ff;
            rd_mux[mms_pkg::F_LEN +: 12]  = len_ff;
         end
         mms_pkg::A_CNT:  rd_mux[3:0]  = cnt_ff;
         mms_pkg::A_STEP: rd_mux[15:0] = step_ff;
         mms_pkg::A_PIN:  rd_mux[0]    = pin_en_ff;
         mms_pkg::A_IDX:  rd_mux[3:0]  = sel_ff;
         mms_pkg::A_MLEN: rd_mux[7:0]  = mlen_ff[sel_ff];
         mms_pkg::A_LOAD: rd_mux[3:0]  = load_idx_ff;
         mms_pkg::A_STAT: rd_mux[8:0]  = {st_ff != mms_pkg::ST_IDLE, load_idx_ff,
                                          2'h0, last_mm_ff, last_hit_ff};
         default: begin
            if (data_hit) begin
               rd_mux = mst_ff[sel_ff][int'(dk)*32 +: 32];
            end
         end
      endcase
   end

   // wishbone answer, one cycle after the request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce) begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // configuration registers, out-of-range writes keep the old value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         type_ff   <= mms_pkg::CMP_OFF;
         dir_ff    <= mms_pkg::RST_DIR;
         snr_ff    <= mms_pkg::RST_SNR;
         smm_ff    <= mms_pkg::RST_SMM;
         cont_ff   <= 1'b0;
         wc_ff     <= mms_pkg::RST_WC;
         nsym_ff   <= 4'h1;
         start_ff  <= mms_pkg::RST_START;
         len_ff    <= mms_pkg::RST_LEN;
         cnt_ff    <= mms_pkg::RST_CNT;
         step_ff   <= mms_pkg::RST_STEP;
         pin_en_ff <= 1'b0;
         sel_ff    <= 4'h0;
      end else if (ce && bus_wr) begin
         case (wb_adr_i)
            mms_pkg::A_CFG: begin
               type_ff <= mms_pkg::mms_cmp_type'(wmerge[mms_pkg::F_TYPE +: 2]);
               dir_ff  <= wmerge[mms_pkg::F_DIR];
               snr_ff  <= wmerge[mms_pkg::F_SNR];
               smm_ff  <= wmerge[mms_pkg::F_SMM];
               cont_ff <= wmerge[mms_pkg::F_CONT];
               wc_ff   <= wmerge[mms_pkg::F_WC +: 8];
               nsym_ff <= wmerge[mms_pkg::F_NSYM +: 4];
            end
            mms_pkg::A_WIN: begin
               if (wmerge[11:0] <= mms_pkg::POS_MAX) begin
                  start_ff <= wmerge[11:0];
               end
               if (wmerge[27:16] != 12'h000 && wmerge[27:16] <= mms_pkg::POS_MAX) begin
                  len_ff <= wmerge[27:16];
               end
            end
            mms_pkg::A_CNT: begin
               if (wmerge[3:0] != 4'h0 && int'(wmerge[3:0]) <= NMST) begin
                  cnt_ff <= wmerge[3:0];
               end
            end
            mms_pkg::A_STEP: begin
               if (wmerge[15:0] != 16'h0000 && wmerge[15:0] <= mms_pkg::STEP_MAX) begin
                  step_ff <= wmerge[15:0];
               end
            end
            mms_pkg::A_PIN: pin_en_ff <= wmerge[0];
            mms_pkg::A_IDX: begin
               if (int'(wmerge[3:0]) < NMST) begin
                  sel_ff <= wmerge[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   // symbols per read cycle seen by the decode engine
   assign eff_symbols = (type_ff == mms_pkg::CMP_SEQ || cont_ff) ? 4'h1 : nsym_ff;

   // new master pin synchroniser and rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
      end else if (ce) begin
         pin_s1_ff <= new_master_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end
   assign pin_pulse = pin_s2_ff & ~pin_s3_ff & pin_en_ff;

   // read cycle sequencer
   assign sym_ready = (st_ff == mms_pkg::ST_IDLE);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff     <= mms_pkg::ST_IDLE;
         scan_ff   <= 4'h0;
         hit_ff    <= 1'b0;
         noread_ff <= 1'b0;
         slen_ff   <= 8'h00;
         sym_ff    <= '0;
      end else if (ce) begin
         case (st_ff)
            mms_pkg::ST_IDLE: begin
               scan_ff <= 4'h0;
               hit_ff  <= 1'b0;
               if (sym_valid) begin
                  sym_ff    <= sym_data;
                  slen_ff   <= sym_len;
                  noread_ff <= sym_noread;
                  if (load_idx_ff != 4'h0 && !sym_noread) begin
                     st_ff <= mms_pkg::ST_LOAD;
                  end else if (type_ff == mms_pkg::CMP_OFF) begin
                     st_ff <= mms_pkg::ST_IDLE;
                  end else if (sym_noread) begin
                     st_ff <= mms_pkg::ST_DONE;
                  end else begin
                     st_ff <= mms_pkg::ST_SCAN;
                  end
               end
            end
            mms_pkg::ST_LOAD: st_ff <= mms_pkg::ST_IDLE;
            mms_pkg::ST_SCAN: begin
               hit_ff <= hit_ff | f_match(sym_ff, slen_ff, mst_ff[scan_ff], mlen_ff[scan_ff],
                                          type_ff, wc_ff, start_ff, len_ff);
               if (type_ff == mms_pkg::CMP_SEQ || scan_ff >= cnt_ff - 4'h1) begin
                  st_ff <= mms_pkg::ST_DONE;
               end else begin
                  scan_ff <= scan_ff + 4'h1;
               end
            end
            mms_pkg::ST_DONE: st_ff <= mms_pkg::ST_IDLE;
            default: st_ff <= mms_pkg::ST_IDLE;
         endcase
      end
   end

   // decide whether the sequential master steps this read
   always_comb begin
      step_go = 1'b0;
      if (st_ff == mms_pkg::ST_DONE && type_ff == mms_pkg::CMP_SEQ) begin
         if (noread_ff) begin
            step_go = snr_ff;
         end else if (hit_ff) begin
            step_go = 1'b1;
         end else begin
            step_go = smm_ff | ~last_mm_ff;
         end
      end
   end

   // stepper operands: decoded value on match, master otherwise
   assign sif.src      = hit_ff ? sym_ff : mst_ff[0];
   assign sif.ndig     = mlen_ff[0];
   assign sif.step_bcd = f_bcd(step_ff);
   assign sif.dec      = dir_ff;

   // result flags and mismatch history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         match_o     <= 1'b0;
         mismatch_o  <= 1'b0;
         last_hit_ff <= 1'b0;
         last_mm_ff  <= 1'b0;
      end else if (ce) begin
         match_o    <= 1'b0;
         mismatch_o <= 1'b0;
         if (st_ff == mms_pkg::ST_DONE && !noread_ff) begin
            match_o     <= hit_ff;
            mismatch_o  <= ~hit_ff;
            last_hit_ff <= hit_ff;
            last_mm_ff  <= ~hit_ff;
         end
      end
   end

   // master load pointer: command, pin, and advance after each store
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         load_idx_ff <= 4'h0;
      end else if (ce) begin
         if (st_ff == mms_pkg::ST_LOAD) begin
            load_idx_ff <= (load_idx_ff >= cnt_ff) ? 4'h0 : load_idx_ff + 4'h1;
         end
         if (bus_wr && wb_adr_i == mms_pkg::A_LOAD) begin
            load_idx_ff <= {3'h0, wmerge[0]};
         end else if (pin_pulse) begin
            load_idx_ff <= 4'h1;
         end
      end
   end

   // master database storage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NMST; i++) begin
            mst_ff[i]  <= '0;
            mlen_ff[i] <= 8'h00;
         end
      end else if (ce) begin
         if (st_ff == mms_pkg::ST_LOAD) begin
            mst_ff[load_idx_ff - 4'h1]  <= sym_ff;
            mlen_ff[load_idx_ff - 4'h1] <= slen_ff;
         end else if (step_go) begin
            mst_ff[0] <= sif.res;
         end else if (bus_wr && data_hit) begin
            mst_ff[sel_ff][int'(dk)*32 +: 32] <= wmerge;
         end else if (bus_wr && wb_adr_i == mms_pkg::A_MLEN && int'(wmerge[7:0]) <= NCH) begin
            mlen_ff[sel_ff] <= wmerge[7:0];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn || !ce);

   property p_eff;
      (type_ff == mms_pkg::CMP_SEQ || cont_ff) |-> eff_symbols == 4'h1;
   endproperty
   a_eff: assert property (p_eff) else $error("symbols per read not forced to one");
   property p_off;
      (sym_ready && sym_valid && type_ff == mms_pkg::CMP_OFF && load_idx_ff == 4'h0)
         |=> sym_ready ##1 !(match_o || mismatch_o);
   endproperty
   a_off: assert property (p_off) else $error("disabled type produced a result");
   property p_win;
      start_ff <= mms_pkg::POS_MAX && len_ff != 12'h000 && len_ff <= mms_pkg::POS_MAX
         && cnt_ff != 4'h0 && int'(cnt_ff) <= NMST;
   endproperty
   a_win: assert property (p_win) else $error("window or count out of range");
   property p_nr;
      (st_ff == mms_pkg::ST_DONE && noread_ff && !snr_ff) |=> $stable(mst_ff[0]);
   endproperty
   a_nr: assert property (p_nr) else $error("master stepped on a no-read");
   property p_nseq;
      (st_ff == mms_pkg::ST_DONE && type_ff != mms_pkg::CMP_SEQ) |-> !step_go;
   endproperty
   a_nseq: assert property (p_nseq) else $error("step outside sequential mode");
   property p_mm;
      (st_ff == mms_pkg::ST_DONE && type_ff == mms_pkg::CMP_SEQ && !noread_ff && !hit_ff
         && smm_ff) |-> step_go ##1 mismatch_o;
   endproperty
   a_mm: assert property (p_mm) else $error("mismatch did not step");
   property p_mm2;
      (st_ff == mms_pkg::ST_DONE && !noread_ff && !hit_ff && !smm_ff && last_mm_ff)
         |-> !step_go;
   endproperty
   a_mm2: assert property (p_mm2) else $error("repeated mismatch stepped");
   property p_step;
      step_go |=> mst_ff[0] == $past(sif.res);
   endproperty
   a_step: assert property (p_step) else $error("stepped master not stored");
   property p_res;
      (st_ff == mms_pkg::ST_DONE && !noread_ff) |=> (match_o ^ mismatch_o) ##1
         !(match_o || mismatch_o);
   endproperty
   a_res: assert property (p_res) else $error("result flag not one cycle");

   c_match: cover property (match_o && type_ff == mms_pkg::CMP_WILD);
   c_seq: cover property (step_go && hit_ff);
   c_nr: cover property (step_go && noread_ff);
   c_load: cover property (st_ff == mms_pkg::ST_LOAD && load_idx_ff == 4'h2);
endmodule // mms_top
`default_nettype wire

// File: common/mms_pkg.sv
package mms_pkg;
   // database and symbol geometry
   localparam int unsigned MAX_MASTERS = 10;
   localparam int unsigned SYM_CHARS   = 16;

   // register byte offsets
   localparam logic [7:0] A_CFG  = 8'h00;
   localparam logic [7:0] A_WIN  = 8'h04;
   localparam logic [7:0] A_CNT  = 8'h08;
   localparam logic [7:0] A_STEP = 8'h0C;
   localparam logic [7:0] A_PIN  = 8'h10;
   localparam logic [7:0] A_IDX  = 8'h14;
   localparam logic [7:0] A_MLEN = 8'h18;
   localparam logic [7:0] A_LOAD = 8'h1C;
   localparam logic [7:0] A_STAT = 8'h20;
   localparam logic [5:0] DWORD_BASE = 6'h10;

   // field positions
   localparam int unsigned F_TYPE = 0;
   localparam int unsigned F_DIR  = 2;
   localparam int unsigned F_SNR  = 3;
   localparam int unsigned F_SMM  = 4;
   localparam int unsigned F_CONT = 5;
   localparam int unsigned F_WC   = 8;
   localparam int unsigned F_NSYM = 16;
   localparam int unsigned F_LEN  = 16;

   // values after reset and limits
   localparam logic [7:0]  RST_WC    = 8'h2A;
   localparam logic [11:0] RST_START = 12'h000;
   localparam logic [11:0] RST_LEN   = 12'h001;
   localparam logic [11:0] POS_MAX   = 12'hBB8;
   localparam logic [15:0] RST_STEP  = 16'h0001;
   localparam logic [15:0] STEP_MAX  = 16'h8000;
   localparam logic [3:0]  RST_CNT   = 4'h1;
   localparam logic        RST_SNR   = 1'b1;
   localparam logic        RST_SMM   = 1'b0;
   localparam logic        RST_DIR   = 1'b0;

   typedef enum logic [1:0] {
      CMP_OFF   = 2'h0,
      CMP_PLAIN = 2'h1,
      CMP_WILD  = 2'h2,
      CMP_SEQ   = 2'h3
   } mms_cmp_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOAD = 4'h2,
      ST_SCAN = 4'h4,
      ST_DONE = 4'h8
   } mms_state_type;
endpackage

// File: common/mms_step_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mms_step_if #(parameter int NCH = 16);
   logic [NCH*8-1:0] src;
   logic [7:0]       ndig;
   logic [19:0]      step_bcd;
   logic             dec;
   logic [NCH*8-1:0] res;
   modport req (output src, ndig, step_bcd, dec, input res);
   modport calc (input src, ndig, step_bcd, dec, output res);
endinterface
`default_nettype wire

// File: logic/mms_digit_step.sv
`timescale 1ns/100ps
`default_nettype none
module mms_digit_step #(
   parameter int NCH = 16
) (
   mms_step_if.calc sif
);
   int         pos;
   logic [4:0] acc;
   logic       cy;
   logic [3:0] sd;
   logic [3:0] cd;

   // ripple decimal add or subtract, carry past the top digit is dropped
   always_comb begin
      sif.res = sif.src;
      cy      = 1'b0;
      pos     = 0;
      acc     = 5'h00;
      sd      = 4'h0;
      cd      = 4'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (i < int'(sif.ndig)) begin
            pos = int'(sif.ndig) - 1 - i;
            sd  = (pos < 5) ? sif.step_bcd[pos*4 +: 4] : 4'h0;
            cd  = sif.src[i*8 +: 4];
            if (!sif.dec) begin
               acc = 5'(cd) + 5'(sd) + 5'(cy);
               cy  = (acc > 5'h09);
               if (cy) begin
                  acc = acc - 5'h0A;
               end
            end else begin
               acc = 5'(cd) - 5'(sd) - 5'(cy);
               cy  = acc[4];
               if (cy) begin
                  acc = acc + 5'h0A;
               end
            end
            sif.res[i*8 +: 8] = {4'h3, acc[3:0]};
         end
      end
   end
endmodule // mms_digit_step
`default_nettype wire

// File: verification/mms_decode_model.sv
`timescale 1ns/100ps
`default_nettype none
// decode engine side: one read result per handshake
module mms_decode_model #(parameter int NCH = 16) (
   input  wire logic             clk,
   input  wire logic             sym_ready,
   output logic                  sym_valid,
   output logic                  sym_noread,
   output logic      [NCH*8-1:0] sym_data,
   output logic      [7:0]       sym_len
);
   initial begin
      sym_valid  = 1'b0;
      sym_noread = 1'b0;
      sym_data   = '0;
      sym_len    = 8'h00;
   end
   // hold result until taken, then scramble the released lines
   task automatic send(input logic [NCH*8-1:0] d, input logic [7:0] n, input logic nr,
                       output logic tmo);
      tmo = 1'b1;
      @(posedge clk);
      sym_valid  <= 1'b1;
      sym_noread <= nr;
      sym_data   <= d;
      sym_len    <= n;
      repeat (40) begin
         @(posedge clk);
         if (sym_ready === 1'b1) begin
            tmo = 1'b0;
            break;
         end
      end
      sym_valid <= 1'b0;
      sym_data  <= ~d;
      sym_len   <= ~n;
   endtask
endmodule // mms_decode_model
`default_nettype wire

// File: verification/test_master_symbol_match_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_master_symbol_match_sequencer;
   logic         clk = 1'b0, rstn = 1'b0, req = 1'b0, wb_we_i = 1'b0, pin = 1'b0;
   logic [7:0]   wb_adr_i = 8'h00;
   logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, rd;
   logic         wb_ack_o, sym_valid, sym_noread, sym_ready, match_o, mismatch_o, dn, snr, smm;
   logic [127:0] sym_data;
   logic [7:0]   sym_len;
   logic [3:0]   eff_symbols;
   int           num_errors = 0, comparisons = 0, m, st, ok = 0;
   always #12.5 clk = ~clk;
   mms_top dut (.clk, .rstn, .ce(1'b1), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i, .wb_adr_i,
      .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .sym_valid, .sym_noread, .sym_data,
      .sym_len, .sym_ready, .new_master_pin(pin), .match_o, .mismatch_o, .eff_symbols);
   mms_decode_model pm (.clk, .sym_ready, .sym_valid, .sym_noread, .sym_data, .sym_len);
   // verdict and end of run
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // classic wishbone cycle, read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req      <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (int i = 0; i <= 20; i++) begin
         @(posedge clk);
         if (wb_ack_o === 1'b1) break;
         if (i == 20) begin
            num_errors++;
            test_done;
         end
      end
      rd = wb_dat_o;
      req <= 1'b0;
   endtask
   function automatic logic [127:0] sy(input string s);
      sy = '0;
      for (int i = 0; i < s.len(); i++) sy[i*8+:8] = s[i];
   endfunction
   // one read result, flags collected over the answer window
   task automatic dec(input string s, input logic nr, input logic [1:0] e);
      logic [1:0] g;
      logic       tmo;
      g = 2'b00;
      pm.send(sy(s), 8'(s.len()), nr, tmo);
      if (tmo) begin
         num_errors++;
         test_done;
      end
      repeat (8) begin
         @(posedge clk);
         g = g | {match_o, mismatch_o};
      end
      chk(32'(g), 32'(e));
   endtask
   task automatic mst(input logic [3:0] i, input string s);
      bus(1'b1, mms_pkg::A_IDX, 32'(i));
      bus(1'b1, mms_pkg::A_MLEN, 32'(s.len()));
      bus(1'b1, 8'h40, 32'(sy(s)));
   endtask
   task automatic cfg(input logic [31:0] d);
      bus(1'b1, mms_pkg::A_CFG, d);
      dn  = d[2];
      snr = d[3];
      smm = d[4];
   endtask
   // counter model: step from decoded value on match, from master otherwise
   function automatic int nx(input int v);
      return dn ? (v + 1000 - st) % 1000 : (v + st) % 1000;
   endfunction
   task automatic seq(input string s, input logic nr);
      logic [1:0] e;
      e = nr ? 2'b00 : (s == $sformatf("%03d", m)) ? 2'b10 : 2'b01;
      dec(s, nr, e);
      if (e == 2'b10) m = nx(s.atoi());
      else if (nr ? snr : (smm || ok)) m = nx(m);
      if (!nr) ok = (e == 2'b10);
   endtask
   initial begin
      st = $urandom(32'hFB9B);
      st = $urandom_range(9, 1);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(1'b0, mms_pkg::A_CFG, 0);
      chk(rd, 32'h00012A08);
      dec("AB12", 1'b0, 2'b00);
      bus(1'b1, mms_pkg::A_WIN, 32'h0BB90BB9);
      bus(1'b0, mms_pkg::A_WIN, 0);
      chk(rd, 32'h00010000);
      bus(1'b1, mms_pkg::A_STEP, 32'h00008001);
      bus(1'b0, mms_pkg::A_STEP, 0);
      chk(rd, 32'h1);
      bus(1'b0, 8'hFC, 0);
      chk(rd, 0);
      bus(1'b1, mms_pkg::A_CNT, 32'hB);
      bus(1'b0, mms_pkg::A_CNT, 0);
      chk(rd, 32'h1);
      cfg(32'h00052A20);
      chk(32'(eff_symbols), 32'h1);
      cfg(32'h00052A09);
      chk(32'(eff_symbols), 32'h5);
      mst(0, "AB12");
      mst(1, "XY");
      bus(1'b1, mms_pkg::A_CNT, 32'h2);
      dec("AB12", 1'b0, 2'b10);
      dec("AB13", 1'b0, 2'b01);
      dec("XY", 1'b0, 2'b10);
      bus(1'b1, mms_pkg::A_WIN, 32'h00020003);
      dec("ZZ12", 1'b0, 2'b10);
      dec("ZZ1", 1'b0, 2'b01);
      cfg(32'h00052A0A);
      mst(0, "C*4");
      mst(1, "AB**");
      dec("CX4", 1'b0, 2'b10);
      dec("CX45", 1'b0, 2'b01);
      dec("AB", 1'b0, 2'b10);
      dec("AB123", 1'b0, 2'b01);
      bus(1'b1, mms_pkg::A_WIN, 32'h00010000);
      bus(1'b1, mms_pkg::A_CNT, 32'h1);
      bus(1'b1, mms_pkg::A_STEP, 32'(st));
      cfg(32'h00052A0B);
      chk(32'(eff_symbols), 32'h1);
      bus(1'b1, mms_pkg::A_LOAD, 32'h1);
      dec("998", 1'b0, 2'b00);
      bus(1'b0, mms_pkg::A_LOAD, 0);
      chk(rd, 0);
      bus(1'b1, mms_pkg::A_PIN, 32'h1);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      bus(1'b0, mms_pkg::A_LOAD, 0);
      chk(rd, 32'h1);
      dec("998", 1'b0, 2'b00);
      m = 998;
      seq("998", 1'b0);
      seq("", 1'b1);
      seq("abc", 1'b0);
      seq("abc", 1'b0);
      seq($sformatf("%03d", m), 1'b0);
      cfg(32'h00052A1F);
      seq("abc", 1'b0);
      seq("abc", 1'b0);
      seq($sformatf("%03d", m), 1'b0);
      cfg(32'h00052A17);
      seq("", 1'b1);
      seq($sformatf("%03d", m), 1'b0);
      test_done;
   end
endmodule // test_master_symbol_match_sequencer
`default_nettype wire
